// [design/clkbuf_cfg_pkg.sv]
/*
 * Shared constants for the serial output-enable slave of the clock fanout
 * buffer: slave address, byte layout, register map and reset values.
 * Assumes a 40 MHz system clock and a standard-mode serial bus.
 */
package clkbuf_cfg_pkg;

    // ------------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------------
    localparam int          BYTE_BITS      = 8;
    localparam logic [6:0]  SLAVE_ADDR     = 7'h69;
    localparam logic        DIR_WRITE      = 1'b0;
    localparam logic [3:0]  ACK_BIT_COUNT  = 4'h8;
    localparam int          BIT_RATE_BPS   = 100000;
    localparam int          MCLK_HZ        = 40000000;
    localparam int          OVERSAMPLE     = MCLK_HZ / BIT_RATE_BPS;

    // ------------------------------------------------------------------
    // Configuration bytes and buffered outputs
    // ------------------------------------------------------------------
    localparam int          CFG_BYTES      = 3;
    localparam int          NUM_OUTPUTS    = 18;
    localparam logic [5:0]  CFG_LAST_IDX   = 6'h02;
    localparam logic [5:0]  IDX_MAX        = 6'h3f;
    localparam logic [7:0]  CFG_RESET      = 8'hff;
    localparam int          HI_OUT_FIRST   = 16;
    localparam int          HI_BIT_FIRST   = 6;

    // ------------------------------------------------------------------
    // Local register port
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_EN0        = 4'h1;
    localparam logic [3:0]  REG_EN1        = 4'h2;
    localparam logic [3:0]  REG_EN2        = 4'h3;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_XFER       = 4'h5;
    localparam logic [7:0]  CTRL_RESET     = 8'h01;
    localparam int          CTRL_SLAVE_EN  = 0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_CMD   = 3'b010,
        ST_COUNT = 3'b011,
        ST_DATA  = 3'b100,
        ST_SKIP  = 3'b101
    } link_stage_t;

endpackage : clkbuf_cfg_pkg

// [design/clkbuf_serial_slave.sv]
/*
 * Write-only two-wire serial slave that holds the output-enable bytes of an
 * eighteen-output clock fanout buffer, plus a small local register port.
 * Assumes mclk_in is far faster than the serial clock and that the bus
 * controller keeps its side of the protocol.
 */
// Chosen here: the plain strobed port and the register addresses.
// Contract
// - Answer only slave address 1101001, ignore every other address.
// - Direction bit is decoded; a read request is not acknowledged.
// - Slave receiver only; never transmits data.
// - Works at 100 kbit/s; 400 kbit/s is optional.
// - Every byte on the link is eight bits.
// - Data bytes arrive lowest first; transfer may stop after any byte.
// - No indexed access; each write starts at byte zero.
// - Block write is address, command code, byte count, data.
// - Byte count equals the number of data bytes that follow.
// - Data bytes beyond the byte count are ignored without error.
// - Write valid once the byte count acknowledge has completed.
// - Bytes zero to two enable outputs, MSB first; zero holds low.
`timescale 1ns/1ps
`default_nettype none

module clkbuf_serial_slave
    import clkbuf_cfg_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic                   reset_in,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n_out,
    input  wire logic                   buf_clk_in,
    output logic [NUM_OUTPUTS-1:0]      buf_out,
    input  wire logic [3:0]             addr_in,
    input  wire logic [7:0]             wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic [7:0]                  rdata_out
);
    import clkbuf_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]             pins_s;
    logic                   scl_s;
    logic                   sda_s;
    logic                   scl_q;
    logic                   sda_q;
    logic                   start_cond;
    logic                   stop_cond;
    logic                   scl_rise;
    logic                   scl_fall;
    link_stage_t            stage;
    link_stage_t            after_ack;
    logic [3:0]             bit_cnt;
    logic [7:0]             shreg;
    logic                   ack_phase;
    logic [7:0]             byte_count;
    logic [5:0]             data_idx;
    logic                   xfer_valid;
    logic [7:0]             xfer_bytes;
    logic                   byte_end;
    logic                   ack_end;
    logic                   commit;
    logic                   addr_hit;
    logic [7:0]             ctrl;
    logic [7:0]             cfg [CFG_BYTES];
    logic [NUM_OUTPUTS-1:0] out_en;
    logic                   active;

    // Index into the configuration bytes that is both declared and stored
    function automatic logic idx_in_range(input logic [5:0] idx,
                                          input logic [7:0] cnt);
        idx_in_range = ({2'h0, idx} < cnt) && (idx <= CFG_LAST_IDX);
    endfunction : idx_in_range

    // ------------------------------------------------------------------
    // Pin synchronisers and bus condition detection
    // ------------------------------------------------------------------
    pin_sync u_pin_sync (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .pins_in  ({scl_in, sda_in}),
        .pins_out (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // Oversampling at OVERSAMPLE clocks per bit in standard mode, a quarter of that in fast mode, covers both
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;
    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;

    assign active   = (stage != ST_IDLE) && (stage != ST_SKIP);
    assign byte_end = active && !ack_phase && scl_fall && (bit_cnt == ACK_BIT_COUNT);
    assign ack_end  = active && ack_phase && scl_fall;
    assign addr_hit = (shreg[7:1] == SLAVE_ADDR)
                      && (shreg[0] == DIR_WRITE)
                      && ctrl[CTRL_SLAVE_EN];
    assign commit   = ack_end && (stage == ST_DATA)
                      && idx_in_range(data_idx, byte_count);

    // ------------------------------------------------------------------
    // Byte framing and protocol stage
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            stage     <= ST_IDLE;
            after_ack <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            ack_phase <= 1'b0;
        end else if (start_cond) begin
            stage     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
        end else if (stop_cond) begin
            stage     <= ST_IDLE;
            ack_phase <= 1'b0;
        end else if (active) begin
            if (!ack_phase && scl_rise && bit_cnt < ACK_BIT_COUNT) begin
                shreg   <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_end) begin
                unique case (stage)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            ack_phase <= 1'b1;
                            after_ack <= ST_CMD;
                        end else begin
                            stage <= ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        ack_phase <= 1'b1;
                        after_ack <= ST_COUNT;
                    end
                    ST_COUNT: begin
                        ack_phase <= 1'b1;
                        after_ack <= ST_DATA;
                    end
                    ST_DATA: begin
                        ack_phase <= 1'b1;
                        after_ack <= ST_DATA;
                    end
                    default: begin
                        stage <= ST_SKIP;
                    end
                endcase
            end
            if (ack_end) begin
                ack_phase <= 1'b0;
                bit_cnt   <= 4'h0;
                stage     <= after_ack;
            end
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge drive, only during the ninth clock
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sda_oe_n_out <= 1'b1;
        end else if (start_cond || stop_cond || ack_end) begin
            sda_oe_n_out <= 1'b1;
        end else if (byte_end && (stage != ST_ADDR || addr_hit)) begin
            sda_oe_n_out <= 1'b0;
        end
    end

    // Only ever pulls low; never sends data back
    assign sda_out = 1'b0;

    // ------------------------------------------------------------------
    // Byte count, data index and transfer status
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            byte_count <= 8'h00;
            data_idx   <= 6'h00;
            xfer_valid <= 1'b0;
            xfer_bytes <= 8'h00;
        end else if (start_cond) begin
            data_idx   <= 6'h00;
            xfer_valid <= 1'b0;
            xfer_bytes <= 8'h00;
        end else if (byte_end && stage == ST_COUNT) begin
            byte_count <= shreg;
        end else if (ack_end && stage == ST_COUNT) begin
            xfer_valid <= 1'b1;
        end else if (ack_end && stage == ST_DATA) begin
            if (data_idx != IDX_MAX) begin
                data_idx <= data_idx + 6'h01;
            end
            if (commit) begin
                xfer_bytes <= xfer_bytes + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration bytes, written lowest first after a valid count
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            for (int i = 0; i < CFG_BYTES; i++) begin
                cfg[i] <= CFG_RESET;
            end
        end else if (commit && xfer_valid) begin
            cfg[data_idx[1:0]] <= shreg;
        end
    end

    // Byte 0 and 1 map bit for bit, byte 2 feeds the two top outputs
    assign out_en = {cfg[2][7:HI_BIT_FIRST], cfg[1], cfg[0]};

    // ------------------------------------------------------------------
    // Buffered clock outputs in the buffer clock domain
    // ------------------------------------------------------------------
    clock_out_gate u_clock_out_gate (
        .buf_clk_in (buf_clk_in),
        .enable_in  (out_en),
        .buf_out    (buf_out)
    );

    // ------------------------------------------------------------------
    // Local register port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctrl <= CTRL_RESET;
        end else if (wr_in && addr_in == REG_CTRL) begin
            ctrl <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                REG_CTRL:   rdata_out <= ctrl;
                REG_EN0:    rdata_out <= cfg[0];
                REG_EN1:    rdata_out <= cfg[1];
                REG_EN2:    rdata_out <= cfg[2];
                REG_STATUS: rdata_out <= {3'h0, xfer_valid, stage, active};
                REG_XFER:   rdata_out <= xfer_bytes;
                default:    rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule : clkbuf_serial_slave

`default_nettype wire

// [design/clock_out_gate.sv]
/*
 * Gates the buffered clock outputs with the configuration enable bits.
 * Assumes enables come from the mclk domain; they are synchronised on the
 * falling edge of the buffer clock so a change never cuts a high phase.
 */
`timescale 1ns/1ps
`default_nettype none

module clock_out_gate
    import clkbuf_cfg_pkg::*;
(
    input  wire logic                   buf_clk_in,
    input  wire logic [NUM_OUTPUTS-1:0] enable_in,
    output logic      [NUM_OUTPUTS-1:0] buf_out
);
    logic [NUM_OUTPUTS-1:0] en_meta;
    logic [NUM_OUTPUTS-1:0] en_sync;

    // ------------------------------------------------------------------
    // Enable crossing, two levels per output
    // ------------------------------------------------------------------
    always_ff @(negedge buf_clk_in) begin
        en_meta <= enable_in;
        en_sync <= en_meta;
    end

    // ------------------------------------------------------------------
    // Disabled outputs are held low
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
            assign buf_out[g] = buf_clk_in & en_sync[g];
        end
    endgenerate

endmodule : clock_out_gate

`default_nettype wire

// [design/pin_sync.sv]
/*
 * Two-flip-flop synchroniser for the serial clock and data pins.
 * Assumes the pins are asynchronous to mclk_in; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    input  wire logic [1:0] pins_in,
    output logic      [1:0] pins_out
);
    logic [1:0] meta;

    // ------------------------------------------------------------------
    // Synchroniser, idles high like the bus
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            meta     <= 2'h3;
            pins_out <= 2'h3;
        end else begin
            meta     <= pins_in;
            pins_out <= meta;
        end
    end

endmodule : pin_sync

`default_nettype wire

// [tb/clkbuf_serial_slave_properties.sv]
/*
 * Port checker for the serial output-enable slave, bound to its top module.
 * Assumes every check runs in the mclk_in domain with reset_in as disable.
 */
`timescale 1ns/1ps
`default_nettype none

module slave_port_checker (
    input wire logic                              mclk_in,
    input wire logic                              reset_in,
    input wire logic                              scl_in,
    input wire logic                              sda_out,
    input wire logic                              sda_oe_n_out,
    input wire logic                              buf_clk_in,
    input wire logic [clkbuf_cfg_pkg::NUM_OUTPUTS-1:0] buf_out,
    input wire logic                              rd_in,
    input wire logic [7:0]                        rdata_out
);
    import clkbuf_cfg_pkg::*;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    // ------------------------------------------------------------------
    // Acknowledge steps, idle read data and output gating
    // ------------------------------------------------------------------
    sequence ack_begins;
        $fell(sda_oe_n_out);
    endsequence
    sequence ninth_fall;
        !sda_oe_n_out && $fell(scl_in);
    endsequence

    ack_level_a: assert property (!sda_oe_n_out |-> !sda_out)
        else $error("data line driven high");
    ack_scl_low_a: assert property (ack_begins |-> !scl_in && !$past(scl_in, 2))
        else $error("acknowledge started while clock high");
    ack_min_a: assert property (ack_begins |-> (!sda_oe_n_out)[*8])
        else $error("acknowledge too short");
    ack_span_a: assert property (ack_begins |-> ##[1:1000] (scl_in && !sda_oe_n_out))
        else $error("acknowledge missed the ninth clock");
    ack_release_a: assert property (ninth_fall |-> ##[1:8] sda_oe_n_out)
        else $error("data line not released after ninth clock");
    sda_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
        else $error("data line changed while clock high");
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    buf_gate_a: assert property (!buf_clk_in |-> buf_out == '0)
        else $error("buffered output high while input clock low");
endmodule : slave_port_checker

bind clkbuf_serial_slave slave_port_checker u_slave_port_checker (
    .mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .buf_clk_in(buf_clk_in), .buf_out(buf_out),
    .rd_in(rd_in), .rdata_out(rdata_out));

`default_nettype wire

// [tb/smbus_host_model.sv]
/*
 * Behavioural bus controller: start, stop and byte writes; open-drain data line, clock driven both ways.
 * Assumes a pull-up on the data line; clock idles high between frames.
 */
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model #(
    parameter int QUARTER_NS = 625
) (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task start_cond;
        sda_low_out = 1'b1;
        #(QUARTER_NS) scl_out = 1'b0;
        #(QUARTER_NS);
    endtask : start_cond

    task stop_cond;
        sda_low_out = 1'b1;
        #(QUARTER_NS) scl_out = 1'b1;
        #(QUARTER_NS) sda_low_out = 1'b0;
        #(QUARTER_NS);
    endtask : stop_cond

    // Eight bits MSB first, then a released ninth bit sampled mid-high
    task put_byte(input logic [7:0] b, output logic acked);
        for (int i = 8; i >= 0; i--) begin
            sda_low_out = (i > 0) ? !b[i-1] : 1'b0;
            #(QUARTER_NS) scl_out = 1'b1;
            #(QUARTER_NS) acked = !sda_in;
            #(QUARTER_NS) scl_out = 1'b0;
            #(QUARTER_NS);
        end
    endtask : put_byte
endmodule : smbus_host_model

`default_nettype wire

// [tb/testbench.sv]
/*
 * Self-checking bench: block writes over the serial link, register reads.
 * Assumes the host model runs the link at 400 kbit/s to keep the run short.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import clkbuf_cfg_pkg::*;

    logic                   mclk_in = 1'b0;
    logic                   reset_in = 1'b1;
    logic                   buf_clk_in = 1'b0;
    logic [3:0]             addr_in = 4'h0;
    logic [7:0]             wdata_in = 8'h00;
    logic                   wr_in = 1'b0;
    logic                   rd_in = 1'b0;
    logic [7:0]             rdata_out;
    logic [NUM_OUTPUTS-1:0] buf_out;
    logic                   scl_line;
    logic                   host_low;
    logic                   sda_out;
    logic                   sda_oe_n_out;
    wire                    sda_line;
    logic [7:0]             q[$];
    int                     errors = 0;
    int                     comparisons = 0;
    int                     cycles = 0;

    always #12.5 mclk_in = ~mclk_in;
    always #16 buf_clk_in = ~buf_clk_in;

    // Pull-up on the data line: low only while some party pulls it
    assign sda_line = !(host_low || (!sda_oe_n_out && !sda_out));

    clkbuf_serial_slave u_clkbuf_serial_slave (
        .mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl_line), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .buf_clk_in(buf_clk_in),
        .buf_out(buf_out), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out));

    smbus_host_model u_host (.sda_in(sda_line), .scl_out(scl_line), .sda_low_out(host_low));

    task conclude;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 check(what, {56'h0, exp}, {56'h0, rdata_out});
    endtask : reg_rd

    // Sends the bytes in q as one frame; all acknowledged or none
    task frame(input logic all_ack);
        logic [63:0] seen;
        logic        ack;
        seen = '0;
        u_host.start_cond();
        foreach (q[i]) begin
            u_host.put_byte(q[i], ack);
            seen[i] = ack;
        end
        u_host.stop_cond();
        check("ack", all_ack ? (64'h1 << q.size()) - 64'h1 : 64'h0, seen);
    endtask : frame

    task check_en(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
        reg_rd(REG_EN0, e0, "en0");
        reg_rd(REG_EN1, e1, "en1");
        reg_rd(REG_EN2, e2, "en2");
        repeat (4) @(posedge buf_clk_in);
        #4 check("buf_out", {46'h0, e2[7:6], e1, e0}, {46'h0, buf_out});
    endtask : check_en

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        check_en(8'hff, 8'hff, 8'hff);
        reg_rd(REG_CTRL, 8'h01, "ctrl");
        reg_rd(4'hf, 8'h00, "unmapped");
        q = {8'hd2, 8'h00, 8'h03, 8'ha5, 8'h3c, 8'hc0};
        frame(1'b1);
        check_en(8'ha5, 8'h3c, 8'hc0);
        q = {8'hd2, 8'h00, 8'h01, 8'h0f, 8'h11, 8'h22};
        frame(1'b1);
        check_en(8'h0f, 8'h3c, 8'hc0);
        q = {8'hd4};
        frame(1'b0);
        q = {8'hd3};
        frame(1'b0);
        q = {8'hd2, 8'h00};
        frame(1'b1);
        reg_rd(REG_STATUS, 8'h00, "status");
        reg_rd(REG_XFER, 8'h00, "xfer");
        q = {8'hd2, 8'h00, 8'h03, 8'h77};
        frame(1'b1);
        check_en(8'h77, 8'h3c, 8'hc0);
        q = {8'hd2, 8'h00, 8'h02, 8'h81, 8'h42};
        frame(1'b1);
        check_en(8'h81, 8'h42, 8'hc0);
        q = {8'hd2, 8'h00, 8'h20};
        for (int i = 0; i < 32; i++) begin
            q.push_back(8'hff - 8'(i));
        end
        frame(1'b1);
        check_en(8'hff, 8'hfe, 8'hfd);
        reg_rd(REG_XFER, 8'h03, "xfer");
        reg_rd(REG_STATUS, 8'h10, "status");
        reg_wr(REG_EN1, 8'h00);
        reg_wr(REG_CTRL, 8'h00);
        q = {8'hd2, 8'h00, 8'h01, 8'h00};
        frame(1'b0);
        check_en(8'hff, 8'hfe, 8'hfd);
        reg_wr(REG_CTRL, 8'h01);
        reg_rd(REG_CTRL, 8'h01, "ctrl");
        conclude();
    end
endmodule : testbench

`default_nettype wire
